// ==== src/rfsl_pkg.sv ====
package rfsl_pkg;

   localparam int NFLAG = 36;
   localparam int AW    = 5;

   // Register byte offsets
   localparam logic [AW-1:0] CMD_OFS     = 5'h00;
   localparam logic [AW-1:0] CTRL_OFS    = 5'h04;
   localparam logic [AW-1:0] CHAN_OFS    = 5'h08;
   localparam logic [AW-1:0] FLAG_LO_OFS = 5'h0c;
   localparam logic [AW-1:0] FLAG_HI_OFS = 5'h10;
   localparam logic [AW-1:0] REPLY_OFS   = 5'h14;
   localparam logic [AW-1:0] SNAP_LO_OFS = 5'h18;
   localparam logic [AW-1:0] SNAP_HI_OFS = 5'h1c;

   // Command word fields
   localparam int CMD_OP_LSB  = 0;
   localparam int CMD_CH_LSB  = 8;
   localparam int CMD_ARG_BIT = 16;

   // Reply word fields
   localparam int RPL_IDX_LSB  = 0;
   localparam int RPL_CH_LSB   = 16;
   localparam int RPL_KIND_LSB = 24;

   // Status bits in the control register read-back
   localparam int CTRL_AGC_BIT   = 0;
   localparam int STAT_RF_BIT    = 8;
   localparam int STAT_BLOCK_BIT = 9;
   localparam int STAT_LED_BIT   = 10;
   localparam int STAT_THR_BIT   = 11;

   localparam logic [7:0] CHAN_RESET = 8'h01;

   // Flag classes
   localparam logic [NFLAG-1:0] BLOCK_MASK = 36'h9_a7f3_c2d5;
   localparam logic [NFLAG-1:0] THR_MASK   = 36'h0_0000_000a;
   localparam logic [NFLAG-1:0] NBOFF_MASK = 36'h0_0000_0400;
   localparam logic [NFLAG-1:0] COMM_MASK  = 36'h0_0000_3000;
   localparam logic [NFLAG-1:0] LED_MASK   = 36'hf_f018_801e;
   localparam int UNSPEC_BIT = 0;
   localparam int I2C_BIT    = 12;
   localparam int SPI_BIT    = 13;

   typedef enum logic [1:0] {
      OP_STATUS,
      OP_CLEAR,
      OP_CHANID,
      OP_RF_SET
   } rfsl_op_type;

   typedef enum logic [3:0] {
      RPL_NONE,
      RPL_MASK,
      RPL_MSG,
      RPL_OK,
      RPL_CHAN
   } rfsl_rpl_type;

endpackage

// ==== src/rfsl_walk_if.sv ====
`timescale 1ns/1ps
interface rfsl_walk_if;
   import rfsl_pkg::*;
   logic [NFLAG-1:0] vec;
   logic [5:0]       start;
   logic             found;
   logic [5:0]       idx;
   modport user   (output vec, output start, input found, input idx);
   modport walker (input vec, input start, output found, output idx);
endinterface

// ==== src/rfsl_sync.sv ====
`timescale 1ns/1ps
module rfsl_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule

// ==== src/rfsl_flag_walker.sv ====
`timescale 1ns/1ps
module rfsl_flag_walker (
   rfsl_walk_if.walker w
);
   import rfsl_pkg::*;

   // Lowest set bit at or above start
   always_comb begin
      w.found = 1'b0;
      w.idx   = 6'h00;
      for (int i = NFLAG - 1; i >= 0; i--) begin
         if (6'(i) >= w.start && w.vec[i]) begin
            w.found = 1'b1;
            w.idx   = 6'(i);
         end
      end
   end
endmodule

// ==== src/rfsl_top.sv ====
`timescale 1ns/1ps
// Function
// - Flags stay latched until the clear command, even after the cause ends.
// - Shutdown flag forces RF enable to 0 and refuses enable until cleared.
// - Clear never turns RF on; it only lifts the enable block.
// - Bit 0 switches RF off and pulses a controller reset.
// - Bits 1 and 3 throttle power when autogain is on, never RF off.
// - Listed shutdown-class bits force RF off and block re-enable.
// - Warning-only bits are latched and reported, RF untouched.
// - Bit 10 forces RF off without blocking re-enable.
// - Bits 12 and 13 turn RF off only for critical measurements.
// - RF-off reactions block until clear unless marked non-blocking.
// - All-zero status word means no error or warning.
// - Bitmask reply carries channel, reserved zero, then the error word.
// - Reported word is the OR of all latched flags.
// - Mode 0 gives bitmask reply; mode 1 one line per flag then OK.
// - Red fault indicator lit while a safe-operating-area error is latched.
// - Channel-id query takes no channel and returns channel, default 1.
// - A cause still present at clear sets its flag again at once.
// - Commands for another channel are ignored without reply.
module rfsl_top
   import rfsl_pkg::*;
(
   input  wire logic             i_sys_clk,
   input  wire logic             i_resetn,
   input  wire logic [AW-1:0]    i_addr,
   input  wire logic [31:0]      i_wdata,
   input  wire logic             i_wr,
   input  wire logic             i_rd,
   input  wire logic [NFLAG-1:0] i_fault_evt,
   input  wire logic [1:0]       i_crit_meas,
   output logic      [31:0]      o_rdata,
   output logic                  o_rf_enable,
   output logic                  o_throttle,
   output logic                  o_ctrl_reset,
   output logic                  o_fault_led
);

   logic             rst_meta_q;
   logic             rst_n_q;
   logic [NFLAG+1:0] mon_sync;
   logic [NFLAG-1:0] evt;
   logic [1:0]       crit;

   logic [NFLAG-1:0] flags_q,  flags_d;
   logic [1:0]       crit_q,   crit_d;
   logic             rf_en_q,  rf_en_d;
   logic             agc_q,    agc_d;
   logic [7:0]       chan_q,   chan_d;
   logic             thr_q,    thr_d;
   logic             creset_q, creset_d;
   logic             led_q,    led_d;
   logic [31:0]      rdata_q,  rdata_d;
   rfsl_rpl_type     kind_q,   kind_d;
   logic [5:0]       idx_q,    idx_d;
   logic [NFLAG-1:0] snap_q,   snap_d;

   logic             cmd_wr;
   rfsl_op_type      cmd_op;
   logic [7:0]       cmd_ch;
   logic             cmd_arg;
   logic             ch_ok;
   logic             do_query;
   logic             do_clear;
   logic             do_rfset;
   logic             blocked;
   logic             off_evt;
   logic             reply_pop;

   rfsl_walk_if walk ();

   // Async assert, synchronous release
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // Monitors are asynchronous to this clock
   rfsl_sync #(
      .W (NFLAG + 2)
   ) u_mon_sync (
      .i_clk   (i_sys_clk),
      .i_rst_n (rst_n_q),
      .i_async ({i_crit_meas, i_fault_evt}),
      .o_sync  (mon_sync)
   );

   assign evt  = mon_sync[NFLAG-1:0];
   assign crit = mon_sync[NFLAG+1:NFLAG];

   rfsl_flag_walker u_walker (
      .w (walk)
   );

   // Command decode
   assign cmd_wr  = i_wr && (i_addr == CMD_OFS);
   assign cmd_op  = rfsl_op_type'(i_wdata[CMD_OP_LSB +: 2]);
   assign cmd_ch  = i_wdata[CMD_CH_LSB +: 8];
   assign cmd_arg = i_wdata[CMD_ARG_BIT];
   assign ch_ok   = (cmd_ch == chan_q);
   assign do_query = cmd_wr && ch_ok && (cmd_op == OP_STATUS);
   assign do_clear = cmd_wr && ch_ok && (cmd_op == OP_CLEAR);
   assign do_rfset = cmd_wr && ch_ok && (cmd_op == OP_RF_SET);
   assign reply_pop = i_rd && (i_addr == REPLY_OFS);

   // Sticky flags
   always_comb begin
      // Set wins over clear so a lingering cause re-latches at once
      flags_d = (flags_q & ~{NFLAG{do_clear}}) | evt;
      crit_d  = (crit_q & ~{2{do_clear}})
              | (crit & evt[SPI_BIT:I2C_BIT]);
   end

   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         flags_q <= '0;
         crit_q  <= '0;
      end else begin
         flags_q <= flags_d;
         crit_q  <= crit_d;
      end
   end

   // RF enable
   always_comb begin
      blocked = |(flags_q & BLOCK_MASK) || (|crit_q);
      // RF is dropped on the event itself, blocking or not
      off_evt = |(evt & (BLOCK_MASK | NBOFF_MASK))
             || |(crit & evt[SPI_BIT:I2C_BIT]);
      rf_en_d = rf_en_q;
      if (off_evt) begin
         rf_en_d = 1'b0;
      end else if (do_rfset) begin
         // Bit 10 is outside the block mask, so it never refuses
         // While blocked RF is already off, so a refusal keeps it off
         rf_en_d = cmd_arg && !blocked;
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rf_en_q <= 1'b0;
      end else begin
         rf_en_q <= rf_en_d;
      end
   end

   // Throttle and LED follow the latched flags one cycle later; reset request rises with the latch
   always_comb begin
      // Reset request fires once per rising flag 0, not while it stays
      creset_d = evt[UNSPEC_BIT] && !flags_q[UNSPEC_BIT];
      thr_d    = agc_q && |(flags_q & THR_MASK);
      led_d    = |(flags_q & LED_MASK);
   end

   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         thr_q    <= 1'b0;
         creset_q <= 1'b0;
         led_q    <= 1'b0;
      end else begin
         thr_q    <= thr_d;
         creset_q <= creset_d;
         led_q    <= led_d;
      end
   end

   // Host settings
   always_comb begin
      agc_d = agc_q;
      if (i_wr && (i_addr == CTRL_OFS)) begin
         agc_d = i_wdata[CTRL_AGC_BIT];
      end
      chan_d = chan_q;
      if (i_wr && (i_addr == CHAN_OFS)) begin
         chan_d = i_wdata[7:0];
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         agc_q  <= 1'b0;
         chan_q <= CHAN_RESET;
      end else begin
         agc_q  <= agc_d;
         chan_q <= chan_d;
      end
   end

   // Reply sequencer
   always_comb begin
      walk.vec   = do_query ? flags_q : snap_q;
      walk.start = do_query ? 6'h00 : 6'(idx_q + 6'h01);
      kind_d = kind_q;
      idx_d  = idx_q;
      snap_d = snap_q;
      if (cmd_wr && (cmd_op == OP_CHANID)) begin
         kind_d = RPL_CHAN;
      end else if (do_query) begin
         // Snapshot keeps a long list steady while new flags arrive
         snap_d = flags_q;
         if (!cmd_arg) begin
            kind_d = RPL_MASK;
            idx_d  = 6'h00;
         end else if (walk.found) begin
            kind_d = RPL_MSG;
            idx_d  = walk.idx;
         end else begin
            kind_d = RPL_OK;
            idx_d  = 6'h00;
         end
      end else if (do_clear) begin
         kind_d = RPL_OK;
         idx_d  = 6'h00;
      end else if (reply_pop) begin
         // Each read of the reply hands out the next line
         if (kind_q == RPL_MSG && walk.found) begin
            idx_d = walk.idx;
         end else if (kind_q == RPL_MSG) begin
            kind_d = RPL_OK;
            idx_d  = 6'h00;
         end else begin
            kind_d = RPL_NONE;
            idx_d  = 6'h00;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         kind_q <= RPL_NONE;
         idx_q  <= 6'h00;
         snap_q <= '0;
      end else begin
         kind_q <= kind_d;
         idx_q  <= idx_d;
         snap_q <= snap_d;
      end
   end

   // Register read port; data only in the cycle after the strobe
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (i_rd) begin
         case (i_addr)
            CTRL_OFS: begin
               rdata_d[CTRL_AGC_BIT]   = agc_q;
               rdata_d[STAT_RF_BIT]    = rf_en_q;
               rdata_d[STAT_BLOCK_BIT] = blocked;
               rdata_d[STAT_LED_BIT]   = led_q;
               rdata_d[STAT_THR_BIT]   = thr_q;
            end
            CHAN_OFS: begin
               rdata_d[7:0] = chan_q;
            end
            FLAG_LO_OFS: begin
               rdata_d = flags_q[31:0];
            end
            FLAG_HI_OFS: begin
               rdata_d[NFLAG-33:0] = flags_q[NFLAG-1:32];
            end
            REPLY_OFS: begin
               // Reserved byte 15:8 stays zero
               rdata_d[RPL_KIND_LSB +: 4] = kind_q;
               rdata_d[RPL_CH_LSB +: 8]   = chan_q;
               rdata_d[RPL_IDX_LSB +: 6]  = idx_q;
            end
            SNAP_LO_OFS: begin
               rdata_d = snap_q[31:0];
            end
            SNAP_HI_OFS: begin
               rdata_d[NFLAG-33:0] = snap_q[NFLAG-1:32];
            end
            default: begin
               rdata_d = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign o_rdata      = rdata_q;
   assign o_rf_enable  = rf_en_q;
   assign o_throttle   = thr_q;
   assign o_ctrl_reset = creset_q;
   assign o_fault_led  = led_q;

endmodule

// ==== testbench/rfsl_top_assertions.sv ====
`timescale 1ns/1ps
module rfsl_top_assertions
   import rfsl_pkg::*;
(
   input wire logic             i_sys_clk,
   input wire logic             i_resetn,
   input wire logic [AW-1:0]    i_addr,
   input wire logic [31:0]      i_wdata,
   input wire logic             i_wr,
   input wire logic [NFLAG-1:0] i_fault_evt,
   input wire logic             o_rf_enable,
   input wire logic             o_ctrl_reset,
   input wire logic             o_fault_led
);
   // Two sync stages plus latch put a pin event 3 to 5 cycles back
   localparam logic [NFLAG-1:0] OFF_M = BLOCK_MASK | NBOFF_MASK | COMM_MASK;
   default clocking @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_resetn);
   property p_rf_rise;
      $rose(o_rf_enable) |-> $past(i_wr) && $past(i_addr) == CMD_OFS
         && $past(i_wdata[1:0]) == 2'h3 && $past(i_wdata[16]);
   endproperty
   a_rf_rise: assert property (p_rf_rise)
      else $error("rf rose without enable command");
   property p_blk_off;
      $rose(|(i_fault_evt & BLOCK_MASK)) |-> ##4 !o_rf_enable;
   endproperty
   a_blk_off: assert property (p_blk_off)
      else $error("rf still on after shutdown event");
   property p_blk_hold;
      !o_rf_enable && |(i_fault_evt & $past(i_fault_evt, 4) & BLOCK_MASK)
         |=> !o_rf_enable;
   endproperty
   a_blk_hold: assert property (p_blk_hold)
      else $error("rf enabled while blocked");
   property p_rf_fall;
      $fell(o_rf_enable) |-> $past(i_wr)
         || |(($past(i_fault_evt, 3) | $past(i_fault_evt, 4)) & OFF_M);
   endproperty
   a_rf_fall: assert property (p_rf_fall)
      else $error("rf dropped without cause");
   property p_rst_pulse;
      o_ctrl_reset |=> !o_ctrl_reset;
   endproperty
   a_rst_pulse: assert property (p_rst_pulse)
      else $error("controller reset not one cycle");
   property p_rst_cause;
      o_ctrl_reset |-> !o_rf_enable
         && ($past(i_fault_evt[0], 3) || $past(i_fault_evt[0], 4));
   endproperty
   a_rst_cause: assert property (p_rst_cause)
      else $error("controller reset without flag 0");
   property p_led_rise;
      $rose(o_fault_led)
         |-> |(($past(i_fault_evt, 4) | $past(i_fault_evt, 5)) & LED_MASK);
   endproperty
   a_led_rise: assert property (p_led_rise)
      else $error("fault led without monitor flag");
   property p_led_hold;
      $fell(o_fault_led) |-> $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3);
   endproperty
   a_led_hold: assert property (p_led_hold)
      else $error("latched flag lost without clear");
   c_rst: cover property (o_ctrl_reset);
   c_led: cover property ($rose(o_fault_led));
   c_off: cover property ($fell(o_rf_enable));
endmodule

bind rfsl_top rfsl_top_assertions chk (
   .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_fault_evt(i_fault_evt),
   .o_rf_enable(o_rf_enable), .o_ctrl_reset(o_ctrl_reset),
   .o_fault_led(o_fault_led)
);

// ==== testbench/rfsl_host.sv ====
`timescale 1ns/1ps
module rfsl_host
   import rfsl_pkg::*;
(
   input  wire logic          i_clk,
   input  wire logic [31:0]   i_rdata,
   output logic      [AW-1:0] o_addr,
   output logic      [31:0]   o_wdata,
   output logic               o_wr,
   output logic               o_rd
);
   initial begin
      o_addr = '0;
      o_wdata = '0;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   // Released lines show inverted data, never the stale value
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] w);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= w;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~w;
   endtask
   task automatic rd(input logic [AW-1:0] a, output logic [31:0] r);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      o_addr <= ~a;
      #1;
      r = i_rdata;
   endtask
   task automatic cmd(input logic [1:0] op, input logic [7:0] ch,
                      input logic m);
      wr(CMD_OFS, {15'h0, m, ch, 6'h0, op});
   endtask
endmodule

// ==== testbench/test_rf_fault_status_latch.sv ====
`timescale 1ns/1ps
module test_rf_fault_status_latch;
   import rfsl_pkg::*;
   typedef struct packed {
      logic [NFLAG-1:0] evt;
      logic [1:0]       crit;
      logic             off;
      logic             blk;
   } rfsl_row_type;
   logic             i_sys_clk;
   logic             i_resetn;
   logic [AW-1:0]    i_addr;
   logic [31:0]      i_wdata;
   logic             i_wr;
   logic             i_rd;
   logic [NFLAG-1:0] i_fault_evt;
   logic [1:0]       i_crit_meas;
   logic [31:0]      o_rdata;
   logic             o_rf_enable;
   logic             o_throttle;
   logic             o_ctrl_reset;
   logic             o_fault_led;
   logic [31:0]      d;
   logic             pv;
   int               error_cnt;
   int               checked;
   rfsl_row_type     rows [9] = '{
      '{36'h1, 2'h0, 1'b1, 1'b1},
      '{36'h2, 2'h0, 1'b0, 1'b0},
      '{36'h4, 2'h0, 1'b1, 1'b1},
      '{36'h20, 2'h0, 1'b0, 1'b0},
      '{36'h400, 2'h0, 1'b1, 1'b0},
      '{36'h1000, 2'h0, 1'b0, 1'b0},
      '{36'h2000, 2'h2, 1'b1, 1'b1},
      '{36'h4_0000_0000, 2'h0, 1'b0, 1'b0},
      '{36'h9_0000_0000, 2'h0, 1'b1, 1'b1}
   };
   rfsl_top uut (
      .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .i_fault_evt(i_fault_evt), .i_crit_meas(i_crit_meas),
      .o_rdata(o_rdata), .o_rf_enable(o_rf_enable),
      .o_throttle(o_throttle), .o_ctrl_reset(o_ctrl_reset),
      .o_fault_led(o_fault_led)
   );
   rfsl_host host (
      .i_clk(i_sys_clk), .i_rdata(o_rdata), .o_addr(i_addr),
      .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd)
   );
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end
   task automatic chk(input string n, input logic [35:0] e, g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chkb(input string n, input logic e, g);
      chk(n, {35'h0, e}, {35'h0, g});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic pulse(input logic [NFLAG-1:0] e, input logic [1:0] c);
      @(posedge i_sys_clk);
      i_fault_evt <= e;
      i_crit_meas <= c;
      repeat (4) @(posedge i_sys_clk);
      i_fault_evt <= '0;
      i_crit_meas <= 2'h0;
      tick(6);
   endtask
   task automatic flags(input logic [NFLAG-1:0] e);
      host.rd(FLAG_LO_OFS, d);
      chk("flags_lo", {4'h0, e[31:0]}, {4'h0, d});
      host.rd(FLAG_HI_OFS, d);
      chk("flags_hi", {32'h0, e[35:32]}, {4'h0, d});
   endtask
   task automatic complete_run();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge i_sys_clk);
      error_cnt++;
      complete_run();
   end
   initial begin
      i_resetn = 1'b0;
      i_fault_evt = '0;
      i_crit_meas = 2'h0;
      error_cnt = 0;
      checked = 0;
      pv = 1'b0;
      repeat (20) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      tick(3);
      chkb("rf_rst", 1'b0, o_rf_enable);
      chkb("thr_rst", 1'b0, o_throttle);
      chkb("led_rst", 1'b0, o_fault_led);
      chkb("creset_rst", 1'b0, o_ctrl_reset);
      host.rd(CHAN_OFS, d);
      chk("chan_rst", 36'h1, {4'h0, d});
      host.rd(5'h03, d);
      chk("unmapped", 36'h0, {4'h0, d});
      flags('0);
      $display("reset test done");
      foreach (rows[i]) begin
         host.cmd(OP_CLEAR, 8'h01, 1'b0);
         tick(2);
         chkb("rf_clr", pv, o_rf_enable);
         host.cmd(OP_RF_SET, 8'h01, 1'b1);
         tick(2);
         chkb("rf_on", 1'b1, o_rf_enable);
         pulse(rows[i].evt, rows[i].crit);
         flags(rows[i].evt);
         chkb("rf_off", !rows[i].off, o_rf_enable);
         host.cmd(OP_RF_SET, 8'h01, 1'b1);
         tick(2);
         chkb("rf_blk", !rows[i].blk, o_rf_enable);
         pv = !rows[i].blk;
         $display("row %0d done", i);
      end
      host.cmd(OP_CLEAR, 8'h01, 1'b0);
      @(posedge i_sys_clk);
      i_fault_evt <= 36'h4;
      tick(6);
      chkb("led", 1'b1, o_fault_led);
      host.cmd(OP_CLEAR, 8'h01, 1'b0);
      tick(2);
      flags(36'h4);
      @(posedge i_sys_clk);
      i_fault_evt <= '0;
      tick(4);
      host.cmd(OP_CLEAR, 8'h01, 1'b0);
      tick(3);
      flags('0);
      chkb("led_off", 1'b0, o_fault_led);
      $display("sticky test done");
      host.rd(REPLY_OFS, d);
      pulse(36'h460, 2'h0);
      host.cmd(OP_STATUS, 8'h02, 1'b0);
      host.rd(REPLY_OFS, d);
      // Channel field always shows the own channel, kind stays none
      chk("rpl_other", 36'h0_0001_0000, {4'h0, d});
      host.cmd(OP_STATUS, 8'h01, 1'b0);
      host.rd(REPLY_OFS, d);
      chk("rpl_mask", 36'h10100, {16'h0, d[27:8]});
      host.rd(SNAP_LO_OFS, d);
      chk("snap", 36'h460, {4'h0, d});
      host.cmd(OP_STATUS, 8'h01, 1'b1);
      foreach (rows[j]) begin
         if (j < 4) begin
            host.rd(REPLY_OFS, d);
            chk("rpl_line", {18'h0, j < 3 ? 12'h201 : 12'h301,
                j == 0 ? 6'd5 : j == 1 ? 6'd6 : j == 2 ? 6'd10 : 6'd0},
                {18'h0, d[27:16], d[5:0]});
         end
      end
      host.cmd(OP_CHANID, 8'h55, 1'b0);
      host.rd(REPLY_OFS, d);
      chk("chan_id", 36'h401, {24'h0, d[27:16]});
      $display("reply test done");
      host.cmd(OP_CLEAR, 8'h01, 1'b0);
      host.cmd(OP_RF_SET, 8'h01, 1'b1);
      @(posedge i_sys_clk);
      i_fault_evt <= 36'h1;
      tick(3);
      chkb("creset", 1'b1, o_ctrl_reset);
      chkb("creset_rf", 1'b0, o_rf_enable);
      tick(1);
      chkb("creset_end", 1'b0, o_ctrl_reset);
      @(posedge i_sys_clk);
      i_fault_evt <= '0;
      tick(4);
      $display("controller reset test done");
      host.cmd(OP_CLEAR, 8'h01, 1'b0);
      host.cmd(OP_RF_SET, 8'h01, 1'b1);
      host.wr(CTRL_OFS, 32'h1);
      pulse(36'h8, 2'h0);
      chkb("thr", 1'b1, o_throttle);
      chkb("thr_rf", 1'b1, o_rf_enable);
      // Autogain, RF on, not blocked, lamp and throttle lit
      host.rd(CTRL_OFS, d);
      chk("ctrl", 36'hd01, {4'h0, d});
      $display("throttle test done");
      complete_run();
   end
endmodule
